/* rtl/sur_access.sv */
`timescale 1ns/1ns
`default_nettype none

module sur_access #(
  parameter logic [23:0] PART_ID = 24'h03_02_01, // arbitrary value
  parameter logic [15:0] TEMP_GAIN = 16'h1000,
  parameter logic [15:0] TEMP_OFFSET = 16'hFFC0,
  parameter logic [127:0] SERIAL = 128'h0F0E0D0C0B0A09080706050403020100
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // lock state and chip erase from the debug port logic
  input wire logic locked,
  input wire logic chip_erase,
  output logic eeprom_erase,
  // cpu access port
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire sur_pkg::sur_area_e cpu_area,
  input wire logic [4:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic cpu_ready,
  output logic cpu_ack,
  output logic cpu_err,
  output logic [7:0] cpu_rdata,
  // debug port access
  input wire logic dbg_req,
  input wire logic dbg_we,
  input wire sur_pkg::sur_area_e dbg_area,
  input wire logic [4:0] dbg_addr,
  input wire logic [7:0] dbg_wdata,
  output logic dbg_ack,
  output logic dbg_err,
  output logic [7:0] dbg_rdata,
  // fuse targets
  output logic load_done,
  output logic [3:0] wdt_window,
  output logic [3:0] wdt_period,
  output logic [2:0] bod_level,
  output logic bod_sample_slow,
  output logic [1:0] bod_active_mode,
  output logic [1:0] bod_sleep_mode,
  output logic [3:0] clock_select,
  output logic [1:0] integrity_check_scope,
  output logic integrity_check_wide,
  output logic [1:0] reset_pin_function,
  output logic keep_eeprom_on_erase,
  output logic [2:0] startup_delay_field,
  output logic [7:0] app_code_size,
  output logic [7:0] boot_area_size,
  // calibration words for the temperature readout
  output logic [15:0] temp_gain_cal,
  output logic signed [15:0] temp_offset_cal
);

  // nonvolatile user row, erased at manufacture
  logic [7:0] user_mem [0:sur_pkg::USER_ROW_BYTES-1] =
    '{default: sur_pkg::USER_ERASED};
  // nonvolatile fuse bytes, factory values
  logic [7:0] fuse_mem [0:sur_pkg::FUSE_COUNT-1] = '{
    sur_pkg::FUSE_WDT_DFLT, sur_pkg::FUSE_BOD_DFLT,
    sur_pkg::FUSE_OSC_DFLT, 8'h00, 8'h00,
    sur_pkg::FUSE_SYSA_DFLT, sur_pkg::FUSE_SYSB_DFLT,
    sur_pkg::FUSE_CODE_DFLT, sur_pkg::FUSE_BOOT_DFLT};

  sur_pkg::sur_state_e state_reg; // loader state
  logic cpu_take; // cpu request accepted this cycle
  logic cpu_ok_next; // cpu access allowed
  logic dbg_ok_next; // debug access allowed
  logic [7:0] cpu_rd_next; // cpu read data
  logic [7:0] dbg_rd_next; // debug read data
  logic cpu_ack_reg;
  logic cpu_err_reg;
  logic [7:0] cpu_rdata_reg;
  logic dbg_ack_reg;
  logic dbg_err_reg;
  logic [7:0] dbg_rdata_reg;
  logic erase_reg;

  // byte of the signature area, zero where nothing is placed
  function automatic logic [7:0] sig_byte(input logic [4:0] a);
    logic [15:0] w;
    logic [7:0] b;
    w = 16'h0000;
    b = 8'h00;
    if (a <= sur_pkg::SIG_ID_LAST) begin
      b = PART_ID[{a[1:0], 3'b000} +: 8];
    end else if (a >= sur_pkg::SIG_TEMP_BASE &&
                 a <= sur_pkg::SIG_TEMP_LAST) begin
      // word n at base plus two n, low byte first
      w = a[1] ? TEMP_OFFSET : TEMP_GAIN;
      b = w[{a[0], 3'b000} +: 8];
    end else if (a >= sur_pkg::SIG_SER_FIRST) begin
      b = SERIAL[{a[3:0], 3'b000} +: 8];
    end
    return b;
  endfunction

  // byte of the fuse area, zero at reserved offsets
  function automatic logic [7:0] fuse_byte(input logic [4:0] a);
    logic [7:0] b;
    b = 8'h00;
    if (a <= sur_pkg::FUSE_BOOT_OFS &&
        (a < sur_pkg::FUSE_RSV_FIRST || a > sur_pkg::FUSE_RSV_LAST)) begin
      b = fuse_mem[a[3:0]];
    end
    return b;
  endfunction

  // cpu waits while the debug port writes, so writes never collide
  assign cpu_ready = ~(dbg_req & dbg_we);
  assign cpu_take = cpu_req & cpu_ready;

  // cpu permission and read data
  always_comb begin
    cpu_ok_next = 1'b0;
    cpu_rd_next = 8'h00;
    unique case (cpu_area)
      sur_pkg::AREA_SIG: begin
        cpu_ok_next = ~cpu_we;
        cpu_rd_next = cpu_we ? 8'h00 : sig_byte(cpu_addr);
      end
      sur_pkg::AREA_USER: begin
        cpu_ok_next = 1'b1;
        cpu_rd_next = cpu_we ? 8'h00 : user_mem[cpu_addr];
      end
      sur_pkg::AREA_FUSE: begin
        cpu_ok_next = ~cpu_we;
        cpu_rd_next = cpu_we ? 8'h00 : fuse_byte(cpu_addr);
      end
      sur_pkg::AREA_NONE: begin
        cpu_ok_next = 1'b0;
      end
    endcase
  end

  // debug permission and read data, gated by the lock
  always_comb begin
    dbg_ok_next = 1'b0;
    unique case (dbg_area)
      sur_pkg::AREA_SIG: begin
        // identifier stays visible to a locked device
        dbg_ok_next = ~dbg_we &
          (~locked | (dbg_addr <= sur_pkg::SIG_ID_LAST));
      end
      sur_pkg::AREA_USER: begin
        dbg_ok_next = dbg_we | ~locked;
      end
      sur_pkg::AREA_FUSE: begin
        dbg_ok_next = ~locked;
      end
      sur_pkg::AREA_NONE: begin
        dbg_ok_next = 1'b0;
      end
    endcase
    dbg_rd_next = 8'h00;
    if (dbg_ok_next && !dbg_we) begin
      if (dbg_area == sur_pkg::AREA_SIG) begin
        dbg_rd_next = sig_byte(dbg_addr);
      end else if (dbg_area == sur_pkg::AREA_USER) begin
        dbg_rd_next = user_mem[dbg_addr];
      end else begin
        dbg_rd_next = fuse_byte(dbg_addr);
      end
    end
  end

  // cpu answer, one cycle after the request is taken
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cpu_ack_reg <= 1'b0;
      cpu_err_reg <= 1'b0;
      cpu_rdata_reg <= 8'h00;
    end else begin
      cpu_ack_reg <= cpu_take;
      cpu_err_reg <= cpu_take & ~cpu_ok_next;
      if (cpu_take) begin
        cpu_rdata_reg <= cpu_ok_next ? cpu_rd_next : 8'h00;
      end
    end
  end

  // debug answer, one cycle after the request
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      dbg_ack_reg <= 1'b0;
      dbg_err_reg <= 1'b0;
      dbg_rdata_reg <= 8'h00;
    end else begin
      dbg_ack_reg <= dbg_req;
      dbg_err_reg <= dbg_req & ~dbg_ok_next;
      if (dbg_req) begin
        dbg_rdata_reg <= dbg_rd_next;
      end
    end
  end

  // user row writes; chip erase never touches it
  always_ff @(posedge clock) begin
    if (reset_n && dbg_req && dbg_we &&
        dbg_area == sur_pkg::AREA_USER) begin
      user_mem[dbg_addr] <= dbg_wdata;
    end else if (reset_n && cpu_take && cpu_we &&
                 cpu_area == sur_pkg::AREA_USER) begin
      user_mem[cpu_addr] <= cpu_wdata;
    end
  end

  // fuse programming, unlocked debug port only
  always_ff @(posedge clock) begin
    if (reset_n && dbg_req && dbg_we && dbg_ok_next &&
        dbg_area == sur_pkg::AREA_FUSE &&
        dbg_addr <= sur_pkg::FUSE_BOOT_OFS &&
        (dbg_addr < sur_pkg::FUSE_RSV_FIRST ||
         dbg_addr > sur_pkg::FUSE_RSV_LAST)) begin
      fuse_mem[dbg_addr[3:0]] <= dbg_wdata;
    end
  end

  // loader: one copy after reset release, then frozen
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= sur_pkg::ST_LOAD;
    end else begin
      unique case (state_reg)
        sur_pkg::ST_LOAD: state_reg <= sur_pkg::ST_RUN;
        sur_pkg::ST_RUN: state_reg <= sur_pkg::ST_RUN;
      endcase
    end
  end

  // target registers take fuse fields only in the load state
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wdt_window <= 4'h0;
      wdt_period <= 4'h0;
      bod_level <= 3'h0;
      bod_sample_slow <= 1'b0;
      bod_active_mode <= 2'h0;
      bod_sleep_mode <= 2'h0;
      clock_select <= 4'h0;
      integrity_check_scope <= 2'h0;
      integrity_check_wide <= 1'b0;
      reset_pin_function <= 2'h0;
      keep_eeprom_on_erase <= 1'b0;
      startup_delay_field <= 3'h0;
      app_code_size <= 8'h00;
      boot_area_size <= 8'h00;
      temp_gain_cal <= 16'h0000;
      temp_offset_cal <= 16'sh0000;
    end else if (state_reg == sur_pkg::ST_LOAD) begin
      wdt_window <= fuse_mem[0][7:4];
      wdt_period <= fuse_mem[0][3:0];
      bod_level <= fuse_mem[1][7:5];
      bod_sample_slow <= fuse_mem[1][4];
      bod_active_mode <= fuse_mem[1][3:2];
      bod_sleep_mode <= fuse_mem[1][1:0];
      clock_select <= fuse_mem[2][3:0];
      integrity_check_scope <= fuse_mem[5][7:6];
      integrity_check_wide <= fuse_mem[5][5];
      reset_pin_function <= fuse_mem[5][3:2];
      keep_eeprom_on_erase <= fuse_mem[5][0];
      startup_delay_field <= fuse_mem[6][2:0];
      app_code_size <= fuse_mem[7];
      boot_area_size <= fuse_mem[8];
      temp_gain_cal <= TEMP_GAIN;
      temp_offset_cal <= $signed(TEMP_OFFSET);
    end
  end

  // eeprom erase request on chip erase
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      erase_reg <= 1'b0;
    end else begin
      erase_reg <= chip_erase & (locked | ~keep_eeprom_on_erase);
    end
  end

  assign cpu_ack = cpu_ack_reg;
  assign cpu_err = cpu_err_reg;
  assign cpu_rdata = cpu_rdata_reg;
  assign dbg_ack = dbg_ack_reg;
  assign dbg_err = dbg_err_reg;
  assign dbg_rdata = dbg_rdata_reg;
  assign eeprom_erase = erase_reg;
  assign load_done = (state_reg == sur_pkg::ST_RUN);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // request steps used by the assertions
  sequence s_cpu_read(sur_pkg::sur_area_e ar, logic [4:0] ad);
    cpu_take && !cpu_we && cpu_area == ar && cpu_addr == ad;
  endsequence
  sequence s_dbg_read_user_locked;
    dbg_req && !dbg_we && dbg_area == sur_pkg::AREA_USER && locked;
  endsequence

  AST_PART_ID_BYTE2: assert property (
    s_cpu_read(sur_pkg::AREA_SIG, 5'h02) |=>
      cpu_ack && !cpu_err && cpu_rdata == PART_ID[23:16])
    else $error("part identifier byte two wrong");
  AST_TEMP_HIGH: assert property (
    s_cpu_read(sur_pkg::AREA_SIG, 5'h07) |=>
      cpu_rdata == TEMP_OFFSET[15:8])
    else $error("calibration word high byte wrong");
  AST_SERIAL_LAST: assert property (
    s_cpu_read(sur_pkg::AREA_SIG, 5'h1F) |=> cpu_rdata == SERIAL[127:120])
    else $error("last serial byte wrong");
  AST_RESERVED_ZERO: assert property (
    s_cpu_read(sur_pkg::AREA_SIG, 5'h03) |=> cpu_rdata == 8'h00 && !cpu_err)
    else $error("reserved signature offset not zero");
  AST_SIG_NO_WRITE: assert property (
    dbg_req && dbg_we && dbg_area == sur_pkg::AREA_SIG |=> dbg_ack && dbg_err)
    else $error("signature write not refused");
  AST_USER_LOCKED_READ: assert property (
    s_dbg_read_user_locked |=> dbg_err && dbg_rdata == 8'h00)
    else $error("locked user row read not refused");
  AST_USER_LOCKED_WRITE: assert property (
    dbg_req && dbg_we && dbg_area == sur_pkg::AREA_USER |=>
      dbg_ack && !dbg_err ##0 user_mem[$past(dbg_addr)] == $past(dbg_wdata))
    else $error("user row write refused or lost");
  AST_ID_WHEN_LOCKED: assert property (
    dbg_req && !dbg_we && dbg_area == sur_pkg::AREA_SIG && locked &&
      dbg_addr <= sur_pkg::SIG_ID_LAST |=> !dbg_err)
    else $error("identifier hidden while locked");
  AST_CPU_FUSE_WRITE: assert property (
    cpu_take && cpu_we && cpu_area == sur_pkg::AREA_FUSE |=> cpu_err)
    else $error("cpu fuse write not refused");
  AST_TARGET_FROZEN: assert property (
    load_done |=> $stable(wdt_window) && $stable(keep_eeprom_on_erase))
    else $error("target changed without reset");
  AST_LOAD_AFTER_RESET: assert property (
    @(posedge clock) disable iff (1'b0)
    $rose(reset_n) |-> !load_done ##1 load_done)
    else $error("fuse load not one cycle after reset");
  AST_ERASE_LOCKED: assert property (
    chip_erase && locked |=> eeprom_erase)
    else $error("locked erase kept the eeprom");

endmodule

`default_nettype wire

/* rtl/sur_pkg.sv */
package sur_pkg;

  // access target selector
  typedef enum logic [1:0] {
    AREA_SIG  = 2'h0, // factory signature area
    AREA_USER = 2'h1, // user data row
    AREA_FUSE = 2'h2, // configuration fuses
    AREA_NONE = 2'h3  // nothing mapped
  } sur_area_e;

  // start-up loader states
  typedef enum logic {
    ST_LOAD = 1'h0, // copy fuses into targets
    ST_RUN  = 1'h1  // targets frozen until next reset
  } sur_state_e;

  // signature area offsets
  localparam logic [4:0] SIG_ID_FIRST = 5'h00;
  localparam logic [4:0] SIG_ID_LAST = 5'h02;
  localparam logic [4:0] SIG_TEMP_BASE = 5'h04;
  localparam logic [4:0] SIG_TEMP_LAST = 5'h07;
  localparam logic [4:0] SIG_SER_FIRST = 5'h10;
  localparam logic [4:0] SIG_SER_LAST = 5'h1F;

  // user data row size in bytes
  localparam int USER_ROW_BYTES = 32;

  // fuse offsets
  localparam logic [4:0] FUSE_WDT_OFS = 5'h00;
  localparam logic [4:0] FUSE_BOD_OFS = 5'h01;
  localparam logic [4:0] FUSE_OSC_OFS = 5'h02;
  localparam logic [4:0] FUSE_RSV_FIRST = 5'h03;
  localparam logic [4:0] FUSE_RSV_LAST = 5'h04;
  localparam logic [4:0] FUSE_SYSA_OFS = 5'h05;
  localparam logic [4:0] FUSE_SYSB_OFS = 5'h06;
  localparam logic [4:0] FUSE_CODE_OFS = 5'h07;
  localparam logic [4:0] FUSE_BOOT_OFS = 5'h08;
  localparam int FUSE_COUNT = 9;

  // factory values of the fuses
  localparam logic [7:0] FUSE_WDT_DFLT = 8'h00;
  localparam logic [7:0] FUSE_BOD_DFLT = 8'h00;
  localparam logic [7:0] FUSE_OSC_DFLT = 8'h00;
  localparam logic [7:0] FUSE_SYSA_DFLT = 8'hC8;
  localparam logic [7:0] FUSE_SYSB_DFLT = 8'h00;
  localparam logic [7:0] FUSE_CODE_DFLT = 8'h00;
  localparam logic [7:0] FUSE_BOOT_DFLT = 8'h00;

  // value of an erased user row byte
  localparam logic [7:0] USER_ERASED = 8'hFF;

endpackage

/* sim/sur_dbg_prog.sv */
`timescale 1ns/1ns
`default_nettype none

module sur_dbg_prog (
  // clock
  input wire logic clock,
  // request lines
  output logic dbg_req,
  output logic dbg_we,
  output sur_pkg::sur_area_e dbg_area,
  output logic [4:0] dbg_addr,
  output logic [7:0] dbg_wdata,
  // answer lines
  input wire logic dbg_ack,
  input wire logic dbg_err,
  input wire logic [7:0] dbg_rdata
);
  // bits of each fuse that are not reserved
  function automatic logic [7:0] keep_mask(input logic [4:0] ofs);
    case (ofs)
      5'h02: return 8'h0F;
      5'h05: return 8'hED;
      5'h06: return 8'h07;
      default: return 8'hFF;
    endcase
  endfunction

  // idle programmer
  initial begin
    dbg_req = 1'b0;
    dbg_we = 1'b0;
    dbg_area = sur_pkg::AREA_NONE;
    dbg_addr = 5'h00;
    dbg_wdata = 8'h00;
  end

  // one transfer; address and data lines show the inverse once released
  task automatic xfer(input logic we, input sur_pkg::sur_area_e area,
                      input logic [4:0] addr, input logic [7:0] wd,
                      output logic ack, output logic err,
                      output logic [7:0] rd);
    logic [7:0] wv;
    wv = wd;
    // reserved fuse bits always go out as zero
    if (we && area == sur_pkg::AREA_FUSE) wv = wd & keep_mask(addr);
    @(negedge clock);
    dbg_req = 1'b1;
    dbg_we = we;
    dbg_area = area;
    dbg_addr = addr;
    dbg_wdata = wv;
    @(negedge clock);
    dbg_req = 1'b0;
    dbg_addr = ~addr;
    dbg_wdata = ~wv;
    ack = dbg_ack;
    err = dbg_err;
    rd = dbg_rdata;
  endtask
endmodule

`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  // bench driven inputs
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic locked = 1'b0;
  logic chip_erase = 1'b0;
  logic cpu_req = 1'b0;
  logic cpu_we = 1'b0;
  sur_pkg::sur_area_e cpu_area = sur_pkg::AREA_SIG;
  logic [4:0] cpu_addr = 5'h00;
  logic [7:0] cpu_wdata = 8'h00;
  // programmer lines and design outputs
  logic dbg_req, dbg_we, dbg_ack, dbg_err;
  sur_pkg::sur_area_e dbg_area;
  logic [4:0] dbg_addr;
  logic [7:0] dbg_wdata, dbg_rdata, cpu_rdata;
  logic cpu_ready, cpu_ack, cpu_err, eeprom_erase, load_done, keep_bit;
  logic [3:0] wdt_window, wdt_period;
  logic [1:0] crc_scope;
  logic [15:0] gain_cal;
  logic signed [15:0] offset_cal;
  logic [2:0] bod_lvl, delay_bits;
  logic [1:0] bod_act, bod_slp, pin_func;
  logic [3:0] clk_sel;
  logic [7:0] code_sz, boot_sz, dr;
  logic bod_slow, crc_wide, da, de;
  // area codes in short form
  localparam sur_pkg::sur_area_e A_SIG = sur_pkg::AREA_SIG;
  localparam sur_pkg::sur_area_e A_USR = sur_pkg::AREA_USER;
  localparam sur_pkg::sur_area_e A_FUS = sur_pkg::AREA_FUSE;
  localparam sur_pkg::sur_area_e A_NON = sur_pkg::AREA_NONE;
  // last answer seen
  logic a, e;
  logic [7:0] r;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;

  // 50 MHz clock
  always #10 clock = ~clock;

  sur_access i_dut (.clock(clock), .reset_n(reset_n), .locked(locked),
    .chip_erase(chip_erase), .eeprom_erase(eeprom_erase),
    .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_area(cpu_area),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_ready(cpu_ready),
    .cpu_ack(cpu_ack), .cpu_err(cpu_err), .cpu_rdata(cpu_rdata),
    .dbg_req(dbg_req), .dbg_we(dbg_we), .dbg_area(dbg_area),
    .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata), .dbg_ack(dbg_ack),
    .dbg_err(dbg_err), .dbg_rdata(dbg_rdata), .load_done(load_done),
    .wdt_window(wdt_window), .wdt_period(wdt_period), .bod_level(bod_lvl),
    .bod_sample_slow(bod_slow), .bod_active_mode(bod_act),
    .bod_sleep_mode(bod_slp), .clock_select(clk_sel),
    .integrity_check_scope(crc_scope), .integrity_check_wide(crc_wide),
    .reset_pin_function(pin_func), .keep_eeprom_on_erase(keep_bit),
    .startup_delay_field(delay_bits), .app_code_size(code_sz),
    .boot_area_size(boot_sz), .temp_gain_cal(gain_cal),
    .temp_offset_cal(offset_cal));

  sur_dbg_prog i_prog (.clock(clock), .dbg_req(dbg_req), .dbg_we(dbg_we),
    .dbg_area(dbg_area), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata),
    .dbg_ack(dbg_ack), .dbg_err(dbg_err), .dbg_rdata(dbg_rdata));

  // verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      final_report();
    end
  end

  // value compare
  task automatic chk_v(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // flag compare
  task automatic chk_b(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  // cpu transfer, held until ready is seen high or eight more cycles pass
  task automatic cpu_xfer(input logic we, input sur_pkg::sur_area_e area,
                          input logic [4:0] addr, input logic [7:0] wd);
    int i = 0;
    @(negedge clock);
    cpu_req = 1'b1;
    cpu_we = we;
    cpu_area = area;
    cpu_addr = addr;
    cpu_wdata = wd;
    @(posedge clock);
    while (cpu_ready !== 1'b1 && i < 8) begin
      i++;
      @(posedge clock);
    end
    @(negedge clock);
    cpu_req = 1'b0;
    cpu_addr = ~addr;
    cpu_wdata = ~wd;
    a = cpu_ack;
    e = cpu_err;
    r = cpu_rdata;
  endtask

  // one access on either port with its expected answer
  task automatic acc(input logic dbg, input logic we,
                     input sur_pkg::sur_area_e area, input logic [4:0] addr,
                     input logic [7:0] wd, input logic xe,
                     input logic [7:0] xr);
    if (dbg) i_prog.xfer(we, area, addr, wd, a, e, r);
    else cpu_xfer(we, area, addr, wd);
    chk_b("ack", 1'b1, a);
    chk_b("err", xe, e);
    // read data, also zero on a refusal
    if (!we || xe) chk_v("rdata", {8'h00, xr}, {8'h00, r});
  endtask

  // chip erase pulse and the erase answer one cycle on
  task automatic erase(input logic xe);
    @(negedge clock);
    chip_erase = 1'b1;
    @(negedge clock);
    chip_erase = 1'b0;
    chk_b("eeprom_erase", xe, eeprom_erase);
  endtask

  // synchronous reset for n cycles
  task automatic do_reset(input int n);
    @(negedge clock);
    reset_n = 1'b0;
    repeat (n) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
  endtask

  // expected signature byte for the chosen parameter values
  function automatic logic [7:0] sig_exp(input logic [4:0] ofs);
    if (ofs <= 5'h02) return {3'h0, ofs} + 8'h01;
    if (ofs >= 5'h10) return {4'h0, ofs[3:0]};
    case (ofs)
      5'h05: return 8'h10;
      5'h06: return 8'hC0;
      5'h07: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction

  // main sequence
  initial begin
    logic [7:0] xs;
    do_reset(16);
    chk_b("load_done", 1'b1, load_done);
    chk_v("crc scope", 16'h0003, {14'h0, crc_scope});
    chk_b("crc wide", 1'b0, crc_wide);
    chk_v("pin function", 16'h0002, {14'h0, pin_func});
    chk_v("bod", 16'h0000, {8'h00, bod_lvl, bod_slow, bod_act, bod_slp});
    chk_v("gain", 16'h1000, gain_cal);
    chk_v("offset", 16'hFFC0, offset_cal);
    // every offset through the cpu first, then through the debug port
    for (int k = 0; k < 64; k++) begin
      xs = sig_exp(k[4:0]);
      acc(k[5], 1'b0, A_SIG, k[4:0], 8'h00, 1'b0, xs);
    end
    acc(1'b0, 1'b0, A_SIG, 5'h06, 8'h00, 1'b0, 8'hC0);
    acc(1'b1, 1'b0, A_SIG, 5'h0C, 8'h00, 1'b0, 8'h00);
    acc(1'b0, 1'b1, A_SIG, 5'h00, 8'h55, 1'b1, 8'h00);
    acc(1'b1, 1'b1, A_SIG, 5'h10, 8'h55, 1'b1, 8'h00);
    acc(1'b0, 1'b0, A_SIG, 5'h00, 8'h00, 1'b0, 8'h01);
    acc(1'b0, 1'b0, A_SIG, 5'h10, 8'h00, 1'b0, 8'h00);
    acc(1'b0, 1'b0, A_NON, 5'h00, 8'h00, 1'b1, 8'h00);
    $display("test signature done");
    acc(1'b0, 1'b1, A_USR, 5'h1F, 8'hA5, 1'b0, 8'h00);
    acc(1'b0, 1'b0, A_USR, 5'h1F, 8'h00, 1'b0, 8'hA5);
    acc(1'b1, 1'b0, A_USR, 5'h1F, 8'h00, 1'b0, 8'hA5);
    // debug write beside a cpu read: the cpu stalls, then sees the new byte
    fork
      i_prog.xfer(1'b1, A_USR, 5'h01, 8'h77, da, de, dr);
      cpu_xfer(1'b0, A_USR, 5'h01, 8'h00);
      begin
        @(negedge clock);
        @(posedge clock);
        chk_b("cpu_ready", 1'b0, cpu_ready);
      end
    join
    chk_b("dbg ack", 1'b1, da);
    chk_b("dbg err", 1'b0, de);
    chk_b("cpu ack", 1'b1, a);
    chk_b("cpu err", 1'b0, e);
    chk_v("cpu rdata", 16'h0077, {8'h00, r});
    chk_b("cpu_ready", 1'b1, cpu_ready);
    locked = 1'b1;
    acc(1'b1, 1'b1, A_USR, 5'h00, 8'h3C, 1'b0, 8'h00);
    acc(1'b1, 1'b0, A_USR, 5'h00, 8'h00, 1'b1, 8'h00);
    acc(1'b0, 1'b0, A_USR, 5'h00, 8'h00, 1'b0, 8'h3C);
    acc(1'b1, 1'b0, A_SIG, 5'h02, 8'h00, 1'b0, 8'h03);
    acc(1'b1, 1'b0, A_SIG, 5'h10, 8'h00, 1'b1, 8'h00);
    acc(1'b1, 1'b0, A_FUS, 5'h00, 8'h00, 1'b1, 8'h00);
    erase(1'b1);
    acc(1'b0, 1'b0, A_USR, 5'h00, 8'h00, 1'b0, 8'h3C);
    locked = 1'b0;
    erase(1'b1);
    $display("test user row done");
    acc(1'b0, 1'b1, A_FUS, 5'h00, 8'h5A, 1'b1, 8'h00);
    acc(1'b1, 1'b1, A_FUS, 5'h00, 8'h5A, 1'b0, 8'h00);
    acc(1'b0, 1'b0, A_FUS, 5'h00, 8'h00, 1'b0, 8'h5A);
    acc(1'b1, 1'b0, A_FUS, 5'h00, 8'h00, 1'b0, 8'h5A);
    acc(1'b1, 1'b1, A_FUS, 5'h01, 8'hB6, 1'b0, 8'h00);
    acc(1'b1, 1'b1, A_FUS, 5'h02, 8'hF3, 1'b0, 8'h00);
    acc(1'b0, 1'b0, A_FUS, 5'h02, 8'h00, 1'b0, 8'h03);
    acc(1'b1, 1'b1, A_FUS, 5'h05, 8'hE9, 1'b0, 8'h00);
    acc(1'b1, 1'b1, A_FUS, 5'h06, 8'hFD, 1'b0, 8'h00);
    acc(1'b1, 1'b1, A_FUS, 5'h07, 8'h21, 1'b0, 8'h00);
    acc(1'b1, 1'b1, A_FUS, 5'h08, 8'h43, 1'b0, 8'h00);
    acc(1'b0, 1'b0, A_FUS, 5'h03, 8'h00, 1'b0, 8'h00);
    chk_v("window", 16'h0000, {12'h0, wdt_window});
    chk_v("clock select", 16'h0000, {12'h0, clk_sel});
    chk_b("keep", 1'b0, keep_bit);
    do_reset(2);
    chk_v("window", 16'h0005, {12'h0, wdt_window});
    chk_v("period", 16'h000A, {12'h0, wdt_period});
    chk_v("bod", 16'h00B6, {8'h00, bod_lvl, bod_slow, bod_act, bod_slp});
    chk_v("clock select", 16'h0003, {12'h0, clk_sel});
    chk_b("crc wide", 1'b1, crc_wide);
    chk_v("pin function", 16'h0002, {14'h0, pin_func});
    chk_v("startup", 16'h0005, {13'h0, delay_bits});
    chk_v("sizes", 16'h2143, {code_sz, boot_sz});
    chk_b("keep", 1'b1, keep_bit);
    erase(1'b0);
    locked = 1'b1;
    erase(1'b1);
    acc(1'b0, 1'b0, A_USR, 5'h1F, 8'h00, 1'b0, 8'hA5);
    $display("test fuses done");
    final_report();
  end
endmodule

`default_nettype wire
